/* logic/gst_map.svh */
// gst_map.svh: register offsets, field positions, reset values, timing counts
// assumes: included by the package and the timer module, bare name include
`ifndef GST_MAP_SVH
`define GST_MAP_SVH
// word offsets (byte address = 4 * index)
`define GST_IDX_CTRL     4'h0
`define GST_IDX_GATE     4'h1
`define GST_IDX_CNT_LO   4'h2
`define GST_IDX_CNT_HI   4'h3
`define GST_IDX_STATUS   4'h4
// control register fields
`define GST_CTRL_RUN     0
`define GST_CTRL_ASYNC   2
`define GST_CTRL_OSCEN   3
`define GST_CTRL_PS_LO   4
`define GST_CTRL_CS_LO   6
// gate register fields
`define GST_GATE_POL     6
`define GST_GATE_EN      7
// status register fields
`define GST_STAT_ROLL    0
`define GST_STAT_GVAL    1
// clock select encodings
`define GST_CS_INSTR     2'h0
`define GST_CS_SYS       2'h1
`define GST_CS_EXT       2'h2
`define GST_CS_LFOSC     2'h3
// reset values
`define GST_CTRL_RST     8'h00
`define GST_GATE_RST     8'h00
`define GST_CNT_RST      16'h0000
// instruction clock is system clock divided by four
`define GST_INSTR_DIV    2'h3
`define GST_SYS_STEP     16'h0004
`define GST_ONE_STEP     16'h0001
`define GST_CNT_MAX      16'hffff
`endif

/* logic/gst_pkg.sv */
// gst_pkg.sv: types shared by the gated sixteen bit timer
// assumes: gst_map.svh sits on the include path
`include "gst_map.svh"
package gst_pkg;
    typedef struct packed {
        logic [3:0]  address;      // word index
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } gst_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } gst_bus_rsp_t;

    // bus answer states, gray coded along idle, busy, done
    typedef enum logic [1:0] {
        GST_BUS_IDLE = 2'b00,
        GST_BUS_BUSY = 2'b01,
        GST_BUS_DONE = 2'b11
    } gst_bus_st_t;

    typedef struct packed {
        gst_bus_st_t bus;
        logic [31:0] rdata;
        logic [7:0]  ctrl;
        logic [7:0]  gate;
        logic [15:0] count;
        logic [2:0]  presc;        // prescale counter, never visible
        logic [1:0]  instr_div;    // system to instruction clock divider
        logic        ext_s1;       // synchroniser first stage
        logic        ext_s2;
        logic        ext_prev;     // last level seen by edge detect
        logic        arm;          // falling edge seen since (re)start
        logic        roll;         // sticky rollover flag
        logic        gval;         // gate level after qualification
        logic        osc_run;      // crystal oscillator enable out
        logic        wreq;         // waitrequest, low only when answering
    } gst_state_t;
endpackage

/* logic/gst_timer.sv */
// gst_timer.sv: 16-bit gated timer/counter with Avalon-MM register slave
// assumes: inputs other than i_ext_count synchronous to i_clk_sys; low-frequency oscillator and
// crystal clock arrive as level signals sampled by the system clock
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "gst_map.svh"

// Summary of operation
// R1 - off unless run; gate enable restricts counting
// R2 - byte writes replace live count halves
// R3 - internal source advances on prescaled ticks
// R4 - select field picks instr, sys, ext/crystal, lfosc
// R5 - system clock source adds four every fourth cycle
// R6 - external rising edge advances counter
// R7 - first rising edge ignored until falling seen
// R8 - prescaler divides by 1, 2, 4, 8
// R9 - prescaler hidden, cleared on count writes
// R10 - oscillator enable starts crystal, runs in sleep
// R11 - software waits for crystal before counting
// R12 - async select bypasses input synchroniser
// R13 - async external counting continues through sleep
// R14 - mode switch may drop or add increment
// R15 - wrap to zero sets sticky rollover flag
// R16 - gate level must equal polarity to count
// R17 - reads return live count bytes, one byte per access
// R18 - off timer holds value, prescaler frozen
module gst_timer (
    input  wire logic            i_clk_sys,    // system clock, 40 MHz
    input  wire logic            i_rst_n,      // synchronous reset, low
    input  wire gst_pkg::gst_bus_req_t i_bus,  // avalon request
    output gst_pkg::gst_bus_rsp_t      o_bus,  // avalon response
    input  wire logic            i_ext_count,  // external count input
    input  wire logic            i_crystal_in, // crystal clock level
    input  wire logic            i_lfosc,      // low-freq osc level
    input  wire logic            i_gate,       // gate input pin
    output logic                 o_osc_enable, // crystal oscillator on
    output logic                 o_rollover,   // sticky rollover flag
    output logic                 o_wake        // wake request from sleep
);
    import gst_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // prescaler terminal count for the selected ratio
    function automatic logic [2:0] ps_mask(input logic [1:0] sel);
        ps_mask = 3'((4'h1 << sel) - 4'h1); // R8
    endfunction

    // true when a write addresses the given word
    function automatic logic wr_hit(input gst_bus_req_t r,
                                    input logic [3:0] idx);
        wr_hit = r.write && (r.address == idx);
    endfunction

    // true when a write addresses either count byte
    function automatic logic cnt_hit(input gst_bus_req_t r);
        cnt_hit = wr_hit(r, `GST_IDX_CNT_LO) ||
                  wr_hit(r, `GST_IDX_CNT_HI);
    endfunction

    // ----------------------------------------------------------------
    // register read decode
    // ----------------------------------------------------------------
    // unmapped words, bits 31:8 and unused status bits read as zero; ctrl and gate return all eight written bits
    function automatic logic [31:0] rd_mux(input gst_state_t s,
                                           input logic [3:0] idx);
        rd_mux = 32'h0000_0000;
        unique case (idx)
            `GST_IDX_CTRL: begin
                rd_mux[7:0] = s.ctrl;
            end
            `GST_IDX_GATE: begin
                rd_mux[7:0] = s.gate;
            end
            `GST_IDX_CNT_LO: begin
                rd_mux[7:0] = s.count[7:0]; // R17
            end
            `GST_IDX_CNT_HI: begin
                rd_mux[7:0] = s.count[15:8]; // R17
            end
            `GST_IDX_STATUS: begin
                rd_mux[`GST_STAT_ROLL] = s.roll;
                rd_mux[`GST_STAT_GVAL] = s.gval;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // source and clock decode
    // ----------------------------------------------------------------
    // level that feeds the edge detector for the chosen source
    function automatic logic src_pick(input logic [1:0] sel,
                                      input logic       async_on,
                                      input logic       osc_on,
                                      input logic       synced,
                                      input logic       raw_ext,
                                      input logic       xtal,
                                      input logic       lfosc);
        src_pick = synced;
        if (sel == `GST_CS_EXT) begin
            if (async_on) begin
                // raw pin, no sync stage, keeps counting in sleep
                src_pick = osc_on ? xtal : raw_ext; // R12 R13
            end else if (osc_on) begin
                src_pick = xtal; // R10
            end else begin
                src_pick = synced; // R6
            end
        end else if (sel == `GST_CS_LFOSC) begin
            src_pick = lfosc; // R4
        end
    endfunction

    // count clock event for the chosen source, before prescaling
    function automatic logic tick_pick(input logic [1:0] sel,
                                       input logic [1:0] div,
                                       input logic       rise,
                                       input logic       armed);
        unique case (sel)
            `GST_CS_INSTR: begin
                tick_pick = (div == `GST_INSTR_DIV); // R4
            end
            `GST_CS_SYS: begin
                // same tick rate as instr, four counts a tick
                tick_pick = (div == `GST_INSTR_DIV); // R5
            end
            `GST_CS_EXT: begin
                tick_pick = rise && armed; // R6
            end
            `GST_CS_LFOSC: begin
                tick_pick = rise; // R4
            end
            default: begin
                tick_pick = 1'b0;
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // counting helpers
    // ----------------------------------------------------------------
    // increment per prescaled tick
    function automatic logic [15:0] step_of(input logic [1:0] sel);
        if (sel == `GST_CS_SYS) begin
            step_of = `GST_SYS_STEP; // R5
        end else begin
            step_of = `GST_ONE_STEP;
        end
    endfunction

    // gate permits counting when its level matches the polarity
    function automatic logic gate_pass(input logic [7:0] g,
                                       input logic       pin);
        gate_pass = (pin == g[`GST_GATE_POL]); // R16
    endfunction

    // prescale counter has reached the selected ratio
    function automatic logic presc_done(input logic [2:0] p,
                                        input logic [1:0] sel);
        presc_done = ((p & ps_mask(sel)) == ps_mask(sel)); // R8
    endfunction

    gst_state_t q;
    gst_state_t d;

    logic [1:0] cs;
    logic [1:0] ps;
    logic       run;
    logic       src_lvl;
    logic       src_rise;
    logic       tick;
    logic       wrap;
    logic       gate_ok;
    logic       cnt_wr;
    logic [15:0] step;
    logic [16:0] sum;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // ------------------------------------------------------------
        // control decode
        // ------------------------------------------------------------
        cs = q.ctrl[`GST_CTRL_CS_LO +: 2];
        ps = q.ctrl[`GST_CTRL_PS_LO +: 2];
        // gate must match polarity when gate enable is set
        gate_ok = gate_pass(q.gate, i_gate); // R16
        d.gval = gate_ok;
        run = q.ctrl[`GST_CTRL_RUN] &&
              (!q.gate[`GST_GATE_EN] || gate_ok); // R1
        cnt_wr = (q.bus == GST_BUS_BUSY) && cnt_hit(i_bus);

        // ------------------------------------------------------------
        // external input path
        // ------------------------------------------------------------
        // two-stage sync; async select reads the raw pin instead
        d.ext_s1 = i_ext_count;
        d.ext_s2 = q.ext_s1;
        src_lvl = src_pick(cs, q.ctrl[`GST_CTRL_ASYNC],
                           q.ctrl[`GST_CTRL_OSCEN], q.ext_s2,
                           i_ext_count, i_crystal_in, i_lfosc);
        // switching sync and async may drop or add one edge here
        d.ext_prev = src_lvl; // R14
        src_rise = src_lvl && !q.ext_prev;

        // ------------------------------------------------------------
        // count clock
        // ------------------------------------------------------------
        // free-running divide by four, not disturbed by writes
        d.instr_div = q.instr_div + 2'h1;
        tick = tick_pick(cs, q.instr_div, src_rise, q.arm);
        step = step_of(cs); // R5

        // ------------------------------------------------------------
        // falling edge arming for counter mode
        // ------------------------------------------------------------
        if (!q.ctrl[`GST_CTRL_RUN] || cnt_wr) begin
            d.arm = 1'b0; // R7
        end else if (!src_lvl && q.ext_prev) begin
            d.arm = 1'b1; // R7
        end

        // ------------------------------------------------------------
        // prescaler and count
        // ------------------------------------------------------------
        sum = {1'b0, q.count} + {1'b0, step};
        wrap = 1'b0;
        if (run && tick) begin // R18
            if (presc_done(q.presc, ps)) begin
                d.presc = 3'h0;
                d.count = sum[15:0]; // R3
                wrap = sum[16];
                if (wrap) begin
                    d.roll = 1'b1; // R15
                end
            end else begin
                d.presc = q.presc + 3'h1; // R8
            end
        end

        // ------------------------------------------------------------
        // avalon slave
        // ------------------------------------------------------------
        // read data latched on the taking edge so it stands while
        // waitrequest is low; the count seen is one cycle old
        unique case (q.bus)
            GST_BUS_IDLE: begin
                if (i_bus.read || i_bus.write) begin
                    d.bus = GST_BUS_BUSY;
                end
                if (i_bus.read) begin
                    d.rdata = rd_mux(q, i_bus.address); // R17
                end
            end
            GST_BUS_BUSY: begin
                d.bus = GST_BUS_DONE;
                if (wr_hit(i_bus, `GST_IDX_CTRL)) begin
                    d.ctrl = i_bus.writedata[7:0];
                end
                if (wr_hit(i_bus, `GST_IDX_GATE)) begin
                    d.gate = i_bus.writedata[7:0];
                end
                if (wr_hit(i_bus, `GST_IDX_CNT_LO)) begin
                    d.count[7:0] = i_bus.writedata[7:0]; // R2
                end
                if (wr_hit(i_bus, `GST_IDX_CNT_HI)) begin
                    d.count[15:8] = i_bus.writedata[7:0]; // R2
                end
                if (cnt_wr) begin
                    d.presc = 3'h0; // R9
                end
                // write one clears, a same-cycle wrap still wins
                if (wr_hit(i_bus, `GST_IDX_STATUS) &&
                    i_bus.writedata[`GST_STAT_ROLL] && !wrap) begin
                    d.roll = 1'b0; // R15
                end
            end
            GST_BUS_DONE: begin
                d.bus = GST_BUS_IDLE;
            end
            default: begin
                d.bus = GST_BUS_IDLE;
            end
        endcase
        // waitrequest low only in the answer cycle, kept in a flop
        d.wreq = (d.bus != GST_BUS_BUSY);

        // ------------------------------------------------------------
        // oscillator
        // ------------------------------------------------------------
        d.osc_run = q.ctrl[`GST_CTRL_OSCEN]; // R10
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q <= '0;
            q.ctrl <= `GST_CTRL_RST;
            q.gate <= `GST_GATE_RST;
            q.count <= `GST_CNT_RST;
            q.wreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign o_bus.readdata = q.rdata;
    assign o_bus.waitrequest = q.wreq;
    assign o_osc_enable = q.osc_run;
    assign o_rollover = q.roll;
    assign o_wake = q.roll;
endmodule

/* verif/gst_count_src.sv */
// gst_count_src.sv: far side, bursts of pulses on the count line
// assumes: line rests low outside bursts, like a stopped clock
`timescale 1ns/1ps
module gst_count_src #(
    parameter int HALF = 3          // cycles per level minus one
) (
    input  wire logic       i_clk_sys, // clock
    input  wire logic       i_go,      // start a burst
    input  wire logic [3:0] i_n,       // rising edges per burst
    output logic            o_line = 1'b0, // count line
    output logic            o_busy     // burst running
);
    // ----------------------------------------
    // burst generator
    // ----------------------------------------
    logic [4:0] left = '0;
    int         cnt = 0;
    assign o_busy = left != 5'h0;
    // even toggle count, so every burst ends low again
    always @(posedge i_clk_sys) begin
        if (i_go && !o_busy) begin
            left <= {i_n, 1'b0};
        end else if (o_busy && cnt == HALF) begin
            cnt <= 0;
            o_line <= ~o_line;
            left <= left - 5'h1;
        end else if (o_busy) begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* verif/gst_timer_checker.sv */
// gst_timer_checker.sv: port assertions for gst_timer
// assumes: one clock domain, bound to every instance
`timescale 1ns/1ps
`include "gst_map.svh"
module gst_timer_checker (
    input wire logic                  i_clk_sys,    // clock
    input wire logic                  i_rst_n,      // reset
    input wire gst_pkg::gst_bus_req_t i_bus,        // request
    input wire gst_pkg::gst_bus_rsp_t o_bus,        // answer
    input wire logic                  o_osc_enable, // osc on
    input wire logic                  o_rollover,   // flag
    input wire logic                  o_wake        // wake
);
    import gst_pkg::*;
    // ----------------------------------------
    // bus and flag relations
    // ----------------------------------------
    logic ack, req, ctl_wr, st_wr;
    // status write counts while held, so a clear is never missed
    assign ack    = !o_bus.waitrequest;
    assign req    = i_bus.read || i_bus.write;
    assign ctl_wr = ack && i_bus.write && i_bus.address == `GST_IDX_CTRL;
    assign st_wr  = i_bus.write && i_bus.address == `GST_IDX_STATUS;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    chk_ack_next: assert property ($rose(req) |-> ##1 ack)
        else $error("answer not one cycle after request");
    chk_ack_cause: assert property ($rose(ack) |-> $past(req))
        else $error("answer without a request");
    chk_ack_short: assert property (ack |=> !ack [*2])
        else $error("answer stood too long");
    chk_ack_gap: assert property (ack |-> $past(o_bus.waitrequest, 2))
        else $error("accesses closer than three cycles");
    chk_idle_wait: assert property (!req |=> !ack)
        else $error("answer while idle");
    chk_rd_upper: assert property (o_bus.readdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    chk_wake_flag: assert property (o_wake == o_rollover)
        else $error("wake differs from flag");
    chk_flag_sticky: assert property (o_rollover && !st_wr |=> o_rollover)
        else $error("flag dropped without a clear");
    chk_osc_cause: assert property ($changed(o_osc_enable) |->
        $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
        else $error("osc enable moved without control write");
endmodule
bind gst_timer gst_timer_checker i_chk (.i_clk_sys, .i_rst_n, .i_bus,
    .o_bus, .o_osc_enable, .o_rollover, .o_wake);

/* verif/tb_top.sv */
// tb_top.sv: self-checking bench for gst_timer
// assumes: gst_count_src stands in for external clock and crystal
`timescale 1ns/1ps
`include "gst_map.svh"
module tb_top;
    import gst_pkg::*;
    typedef struct packed {
        logic [7:0] gate;
        logic [7:0] ctrl;
        logic [7:0] exp;
    } gst_row_t;
    gst_row_t     rows [8];
    gst_bus_req_t req;
    gst_bus_rsp_t rsp;
    logic         clk, rst_n, gate, go, line, busy, osc, roll, wake;
    logic [31:0]  rd;
    logic [15:0]  cnt;
    int           err_total, n_compared, i, k;
    // ----------------------------------------
    // design, far side, clock and tasks
    // ----------------------------------------
    gst_timer i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus(req),
        .o_bus(rsp), .i_ext_count(line), .i_crystal_in(line),
        .i_lfosc(line), .i_gate(gate), .o_osc_enable(osc),
        .o_rollover(roll), .o_wake(wake));
    gst_count_src i_src (.i_clk_sys(clk), .i_go(go), .i_n(4'h5),
        .o_line(line), .o_busy(busy));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [7:0] d);
        req <= '{a, !w, w, {24'h0, d}};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.waitrequest !== 1'b0 && k < 20);
        if (k >= 20) begin
            err_total++;
            complete_run();
        end
        rd = rsp.readdata;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wrcnt(input logic [15:0] v);
        bus(`GST_IDX_CNT_LO, 1'b1, v[7:0]);
        bus(`GST_IDX_CNT_HI, 1'b1, v[15:8]);
    endtask
    task automatic rdcnt;
        bus(`GST_IDX_CNT_LO, 1'b0, 8'h00);
        cnt[7:0] = rd[7:0];
        bus(`GST_IDX_CNT_HI, 1'b0, 8'h00);
        cnt[15:8] = rd[7:0];
    endtask
    task automatic burst;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge clk);
        check("burst ended", 16'h1, 16'(k < 200));
        repeat (8) @(posedge clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{8'h00, 8'h81, 8'h04}, '{8'h00, 8'h85, 8'h04},
                 '{8'h00, 8'h89, 8'h04}, '{8'h00, 8'hc1, 8'h05},
                 '{8'h80, 8'h81, 8'h04}, '{8'h40, 8'h81, 8'h04},
                 '{8'hc0, 8'h81, 8'h00}, '{8'h00, 8'h80, 8'h00}};
        {req, gate, go, rst_n, err_total, n_compared} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdcnt();
        check("count at reset", 16'h0000, cnt);
        foreach (rows[i]) begin
            bus(`GST_IDX_GATE, 1'b1, rows[i].gate);
            bus(`GST_IDX_CTRL, 1'b1, rows[i].ctrl & 8'hfe);
            repeat (16) @(posedge clk);
            check("osc enable", 16'(rows[i].ctrl[3]), 16'(osc));
            wrcnt(16'h0000);
            bus(`GST_IDX_CTRL, 1'b1, rows[i].ctrl);
            burst();
            bus(`GST_IDX_CTRL, 1'b1, 8'h00);
            rdcnt();
            check("edge count", 16'(rows[i].exp), cnt);
            $display("row %0d done", i);
        end
        wrcnt(16'ha55a);
        bus(4'h7, 1'b1, 8'hff);
        bus(4'h7, 1'b0, 8'h00);
        check("unmapped read", 16'h0000, rd[15:0]);
        repeat (40) @(posedge clk);
        rdcnt();
        check("held count", 16'ha55a, cnt);
        $display("register test done");
        for (i = 0; i < 4; i++) begin
            wrcnt(16'h0000);
            bus(`GST_IDX_CTRL, 1'b1, {2'b00, i[1:0], 4'h1});
            repeat (256) @(posedge clk);
            bus(`GST_IDX_CTRL, 1'b1, 8'h00);
            rdcnt();
            k = 256 / (4 << i);
            check("prescale", 16'h1, 16'(cnt + 1 >= k && cnt <= k + 1));
        end
        $display("prescale test done");
        wrcnt(16'h0000);
        bus(`GST_IDX_CTRL, 1'b1, 8'h41);
        repeat (64) @(posedge clk);
        bus(`GST_IDX_CTRL, 1'b1, 8'h00);
        rdcnt();
        check("four steps", 16'h0, 16'(cnt[1:0]));
        check("sys rate", 16'h1, 16'(cnt >= 60 && cnt <= 72));
        wrcnt(16'hfffe);
        bus(`GST_IDX_CTRL, 1'b1, 8'h81);
        burst();
        bus(`GST_IDX_CTRL, 1'b1, 8'h00);
        rdcnt();
        check("wrapped count", 16'h0002, cnt);
        check("flag and wake", 16'h3, {14'h0, roll, wake});
        bus(`GST_IDX_STATUS, 1'b1, 8'h01);
        check("flag cleared", 16'h0, 16'(roll));
        $display("rollover test done");
        complete_run();
    end
endmodule
